// file: inc/umad_pkg.sv
// Constants and types shared by the upper memory address decoder
package umad_pkg;

  // --------------------------------------------------------------------
  // Register map (word index, byte address is index times four)
  // --------------------------------------------------------------------
  localparam int unsigned NREG        = 11;
  localparam logic [3:0] IDX_PAM      = 4'h0;
  localparam logic [3:0] IDX_MEMCTL   = 4'h1;
  localparam logic [3:0] IDX_SMMCTL   = 4'h2;
  localparam logic [3:0] IDX_HIGH_SMM_SEGMENT     = 4'h3;
  localparam logic [3:0] IDX_GFXCFG   = 4'h4;
  localparam logic [3:0] IDX_LMEM     = 4'h5;
  localparam logic [3:0] IDX_MMIO     = 4'h6;
  localparam logic [3:0] IDX_AGPWIN   = 4'h7;
  localparam logic [3:0] IDX_AGPPF    = 4'h8;
  localparam logic [3:0] IDX_APER     = 4'h9;
  localparam logic [3:0] IDX_STATUS   = 4'ha;

  // Writable bits of each stored register, reset value of all of them
  localparam logic [31:0] WMASK_PAM    = 32'h0000_03ff;
  localparam logic [31:0] WMASK_MEMCTL = 32'h0001_3fff;
  localparam logic [31:0] WMASK_SMMCTL = 32'h0000_0007;
  localparam logic [31:0] WMASK_HIGH_SMM_SEGMENT   = 32'hfffe_0000;
  localparam logic [31:0] WMASK_GFXCFG = 32'h0000_0003;
  localparam logic [31:0] WMASK_RANGE  = 32'h0fff_0fff;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int unsigned PAM_F_RE     = 8;   // System BIOS read enable
  localparam int unsigned PAM_F_WE     = 9;   // System BIOS write enable
  localparam int unsigned MEM_HOLE     = 16;  // fixed_hole_control enable
  localparam int unsigned SMM_HIGH_SMM_SEGMENT_EN  = 0;
  localparam int unsigned SMM_TOP_SMM_SEGMENT_EN  = 1;
  localparam int unsigned SMM_SIZE     = 2;   // extended_smm_memory_control_size_field
  localparam int unsigned GFX_IGD      = 0;
  localparam int unsigned GFX_AGP      = 1;

  // --------------------------------------------------------------------
  // Address constants (64 KB units unless stated; SMM_LOW_BASE is a byte address)
  // --------------------------------------------------------------------
  localparam logic [13:0] TOM_MAX      = 14'h2000;  // 512 MB
  localparam logic [13:0] TOP_SMM_SEGMENT_SZ_512K = 14'h0008;
  localparam logic [13:0] TOP_SMM_SEGMENT_SZ_1M   = 14'h0010;
  localparam logic [11:0] HOLE_MB      = 12'h00f;   // 15 MB, 1 MB units
  localparam logic [15:0] SEG_A0       = 16'h000a;
  localparam logic [15:0] SEG_E0       = 16'h000e;
  localparam logic [15:0] SEG_F0       = 16'h000f;
  localparam logic [15:0] SEG_1MB      = 16'h0010;
  localparam logic [31:0] SMM_LOW_BASE = 32'h000a_0000;

  // --------------------------------------------------------------------
  // Request sources and decode targets
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_CPU,
    SRC_HUB,
    SRC_AGP
  } src_t;

  typedef enum logic [2:0] {
    TGT_DRAM,
    TGT_HUB,
    TGT_GFX,
    TGT_AGP,
    TGT_TERM,
    TGT_REFUSE
  } tgt_t;

endpackage

// file: rtl/upper_memory_address_decoder.sv
// Address decoder steering host and hub accesses to DRAM, hub or graphics
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps

module upper_memory_address_decoder (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,

  // Classic Wishbone register slave
  input  wire logic                   wb_cyc_in,
  input  wire logic                   wb_stb_in,
  input  wire logic                   wb_we_in,
  input  wire logic [7:0]             wb_adr_in,
  input  wire logic [3:0]             wb_sel_in,
  input  wire logic [31:0]            wb_dat_in,
  output logic      [31:0]            wb_dat_out,
  output logic                        wb_ack_out,

  // Decode request
  input  wire logic                   req_valid_in,
  input  wire logic [31:0]            req_addr_in,
  input  wire logic                   req_write_in,
  input  wire logic                   req_wb_in,
  input  wire logic                   req_smm_in,
  input  wire umad_pkg::src_t         req_src_in,

  // Decode answer
  output logic                        rsp_valid_out,
  output umad_pkg::tgt_t              rsp_target_out,
  output logic      [31:0]            rsp_addr_out,
  output logic                        rsp_write_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // One record holds every flop: configuration, bus answer, decode
  // answer. Status is rebuilt on each read from live fields, so it
  // has no slot of its own and cannot go stale.
  typedef struct packed {
    logic [umad_pkg::NREG-2:0][31:0] regs;
    logic                            ack;
    logic [31:0]                     rdat;
    logic                            rsp_valid;
    umad_pkg::tgt_t                  rsp_tgt;
    logic [31:0]                     rsp_addr;
    logic                            rsp_write;
    umad_pkg::tgt_t                  last_tgt;
    logic [7:0]                      refuse_cnt;
  } state_t;

  // Present value, and the value taken at the next edge
  state_t st_q;
  state_t st_d;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Pure decoding only; each is used in several places or keeps a
  // range test in the priority chain or the register write readable.

  // Writable bits per register index; unmapped slots take nothing
  function automatic logic [31:0] wmask(input logic [3:0] idx);
    logic [31:0] m;
    m = 32'h0000_0000;

    unique case (idx)
      umad_pkg::IDX_PAM:    m = umad_pkg::WMASK_PAM;
      umad_pkg::IDX_MEMCTL: m = umad_pkg::WMASK_MEMCTL;
      umad_pkg::IDX_SMMCTL: m = umad_pkg::WMASK_SMMCTL;
      umad_pkg::IDX_HIGH_SMM_SEGMENT:   m = umad_pkg::WMASK_HIGH_SMM_SEGMENT;
      umad_pkg::IDX_GFXCFG: m = umad_pkg::WMASK_GFXCFG;
      umad_pkg::IDX_LMEM,
      umad_pkg::IDX_MMIO,
      umad_pkg::IDX_AGPWIN,
      umad_pkg::IDX_AGPPF,
      umad_pkg::IDX_APER:   m = umad_pkg::WMASK_RANGE;
      default:              m = 32'h0000_0000;
    endcase

    return m;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel,
                                        input logic [31:0] msk);
    logic [31:0] lane;
    logic [31:0] res;

    // Only lanes both selected and writable change
    lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
    res  = (old_v & ~lane) | (new_v & lane);
    return res;
  endfunction

  // Base/limit window in 1 MB units: base in [11:0], limit in [27:16]
  // The limit is inclusive; a limit below the base leaves the window
  // empty, which is how software switches a window off.
  function automatic logic win_hit(input logic [31:0] r,
                                   input logic [11:0] mb);
    return (mb >= r[11:0]) && (mb <= r[27:16]);
  endfunction

  // Aperture: base in [11:0], size mask in [27:16], 1 MB units
  // Set mask bits vary inside the aperture, so its size is a power
  // of two and the base is aligned down to that size.
  function automatic logic aper_hit(input logic [31:0] r,
                                    input logic [11:0] mb);
    return (mb & ~r[27:16]) == (r[11:0] & ~r[27:16]);
  endfunction

  // ----------------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------------
  // Stored words by role, then the derived memory limits
  logic [31:0] pam_r;
  logic [31:0] mem_r;
  logic [31:0] smm_r;
  logic [31:0] high_smm_segment_r;
  logic [31:0] gfx_r;

  logic [13:0] top_of_memory_limit;
  logic [13:0] top_smm_segment_sz;
  logic [13:0] usable;

  logic        top_smm_segment_en;
  logic        high_smm_segment_en;

  // Sizes are in 64 KB units, so both top segment sizes fall on
  // whole units and need no rounding.
  // Configuration fields used by both decode and status
  always_comb begin
    pam_r   = st_q.regs[umad_pkg::IDX_PAM];
    mem_r   = st_q.regs[umad_pkg::IDX_MEMCTL];
    smm_r   = st_q.regs[umad_pkg::IDX_SMMCTL];
    high_smm_segment_r  = st_q.regs[umad_pkg::IDX_HIGH_SMM_SEGMENT];
    gfx_r   = st_q.regs[umad_pkg::IDX_GFXCFG];

    // Segment enables
    high_smm_segment_en = smm_r[umad_pkg::SMM_HIGH_SMM_SEGMENT_EN];
    top_smm_segment_en = smm_r[umad_pkg::SMM_TOP_SMM_SEGMENT_EN];

    // A larger programmed value would run past the DRAM that exists
    top_of_memory_limit = (mem_r[13:0] > umad_pkg::TOM_MAX) ? umad_pkg::TOM_MAX
                                            : mem_r[13:0];

    // One control bit picks between the two segment sizes
    top_smm_segment_sz = smm_r[umad_pkg::SMM_SIZE] ? umad_pkg::TOP_SMM_SEGMENT_SZ_1M
                                        : umad_pkg::TOP_SMM_SEGMENT_SZ_512K;

    // Guard against a top of memory smaller than the segment
    if (top_smm_segment_en && (top_of_memory_limit >= top_smm_segment_sz)) begin
      usable = top_of_memory_limit - top_smm_segment_sz;
    end else begin
      usable = top_of_memory_limit;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Decode result, then the pieces it is built from
  umad_pkg::tgt_t dec_tgt;
  logic [31:0]    dec_addr;

  logic [15:0]    seg64;
  logic [11:0]    mb;
  logic [2:0]     pam_pair;
  logic           attr_on;
  logic           smm_ok;
  logic           cpu;

  // Strict order: compatibility area, high SMM segment, main DRAM
  // with top segment and hole, then PCI. Ranges must not overlap;
  // where software lets them, the earlier test wins.
  // Priority decode of one request, SMM flag sampled with the address
  always_comb begin
    dec_tgt  = umad_pkg::TGT_HUB;
    dec_addr = req_addr_in;

    // Address in 64 KB and in 1 MB units
    seg64    = req_addr_in[31:16];
    mb       = req_addr_in[31:20];

    // Mode flags travel with this request, never a stale copy
    cpu      = (req_src_in == umad_pkg::SRC_CPU);
    smm_ok   = cpu && (req_smm_in || req_wb_in);

    // Attribute pair of the 16 KB segment, used in the E area only
    pam_pair = {1'b0, req_addr_in[15:14]};
    attr_on  = 1'b0;

    if (seg64 < umad_pkg::SEG_A0) begin
      dec_tgt = umad_pkg::TGT_DRAM;
    end else if (seg64 < umad_pkg::SEG_E0) begin
      // Video and expansion areas are left to the hub here
      dec_tgt = umad_pkg::TGT_HUB;
    end else if (seg64 == umad_pkg::SEG_E0) begin
      // Each 16 KB segment owns a read/write enable pair
      attr_on = req_write_in ? pam_r[{pam_pair, 1'b1}]
                             : pam_r[{pam_pair, 1'b0}];
      // Disabled segments fall through to the hub at the same address
      dec_tgt = attr_on ? umad_pkg::TGT_DRAM : umad_pkg::TGT_HUB;
    end else if (seg64 == umad_pkg::SEG_F0) begin
      attr_on = req_write_in ? pam_r[umad_pkg::PAM_F_WE]
                             : pam_r[umad_pkg::PAM_F_RE];
      dec_tgt = attr_on ? umad_pkg::TGT_DRAM : umad_pkg::TGT_HUB;
    end else if (high_smm_segment_en && (req_addr_in[31:17] == high_smm_segment_r[31:17])) begin
      // A 128 KB window above the compatibility area; only the low
      // 17 address bits carry over into the low SMM range.
      // The DRAM under this window is never reached directly
      if (!cpu) begin
        dec_tgt = umad_pkg::TGT_REFUSE;
      end else if (smm_ok) begin
        dec_tgt  = umad_pkg::TGT_DRAM;
        dec_addr = umad_pkg::SMM_LOW_BASE
                 | {15'h0000, req_addr_in[16:0]};
      end else begin
        dec_tgt = umad_pkg::TGT_TERM;
      end
    end else if ((seg64 >= umad_pkg::SEG_1MB) && (seg64 < {2'b00, top_of_memory_limit}))
    begin
      // The top segment is carved from the top of DRAM. A plain read
      // outside SMM ends on the hub as a floating bus, so cached
      // code must not touch it outside SMM.
      if (top_smm_segment_en && (seg64 >= {2'b00, usable})) begin
        if (!cpu) begin
          dec_tgt = umad_pkg::TGT_REFUSE;
        end else if (smm_ok) begin
          dec_tgt = umad_pkg::TGT_DRAM;
        end else begin
          dec_tgt = umad_pkg::TGT_HUB;
        end
      end else if (mem_r[umad_pkg::MEM_HOLE] && (mb == umad_pkg::HOLE_MB))
      begin
        // The DRAM behind the hole is simply lost, no remap above top
        dec_tgt = umad_pkg::TGT_HUB;
      end else begin
        dec_tgt = umad_pkg::TGT_DRAM;
      end
    end else begin
      // PCI range; overlap with APIC or high BIOS is the software's job
      dec_tgt = umad_pkg::TGT_HUB;
      // With both graphics modes set the internal device windows win and
      // the AGP ranges decode only outside them.
      if (gfx_r[umad_pkg::GFX_IGD] &&
          (win_hit(st_q.regs[umad_pkg::IDX_LMEM], mb) ||
           win_hit(st_q.regs[umad_pkg::IDX_MMIO], mb))) begin
        dec_tgt = umad_pkg::TGT_GFX;
      end else if (gfx_r[umad_pkg::GFX_AGP]) begin
        if (aper_hit(st_q.regs[umad_pkg::IDX_APER], mb)) begin
          dec_tgt = umad_pkg::TGT_DRAM;
        end else if (win_hit(st_q.regs[umad_pkg::IDX_AGPWIN], mb) ||
                     win_hit(st_q.regs[umad_pkg::IDX_AGPPF], mb)) begin
          dec_tgt = umad_pkg::TGT_AGP;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Bus decode helpers and the rebuilt status word
  logic [3:0]  idx;
  logic        hit;
  logic        bus_req;
  logic [31:0] status_w;

  // No wait states: the answer comes one cycle after the take. A
  // strobe held through the acknowledge is not taken twice, since
  // the registered acknowledge blocks it for that cycle.
  // Register file, bus answer and answer pipeline
  always_comb begin
    // Everything but the ack and answer valid pulses holds unless an access or a request changes it
    st_d     = st_q;
    idx      = wb_adr_in[5:2];
    hit      = (wb_adr_in[7:6] == 2'b00) && (idx <= umad_pkg::IDX_STATUS);
    bus_req  = wb_cyc_in && wb_stb_in && !st_q.ack;
    status_w = {2'b00, usable, 5'h00, st_q.last_tgt, st_q.refuse_cnt};

    // Ack one cycle after the strobe, dropped in the following cycle
    st_d.ack = bus_req;
    if (bus_req) begin
      st_d.rdat = 32'h0000_0000;
      // Unmapped words read as zero
      if (hit && (idx == umad_pkg::IDX_STATUS)) begin
        st_d.rdat = status_w;
      end else if (hit) begin
        st_d.rdat = st_q.regs[idx];
      end

      // Unmapped and read-only words swallow writes and still ack
      if (wb_we_in && hit && (idx != umad_pkg::IDX_STATUS)) begin
        st_d.regs[idx] = merge(st_q.regs[idx], wb_dat_in, wb_sel_in,
                               wmask(idx));
      end
    end

    // One-cycle answer per request. Target, address and direction
    // hold until the next one; only the valid pulse marks news.
    st_d.rsp_valid = req_valid_in;
    if (req_valid_in) begin
      st_d.rsp_tgt   = dec_tgt;
      st_d.rsp_addr  = dec_addr;
      st_d.rsp_write = req_write_in;
      st_d.last_tgt  = dec_tgt;

      // Saturate so software can see a storm without wrap-around
      if ((dec_tgt == umad_pkg::TGT_REFUSE ||
           dec_tgt == umad_pkg::TGT_TERM) &&
          (st_q.refuse_cnt != 8'hff)) begin
        st_d.refuse_cnt = st_q.refuse_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset clears every stored word: BIOS segments disabled, both SMM
  // segments closed, the hole shut and the graphics modes off.
  // The answer target resets to the zero code, which is DRAM.
  // All attributes disabled after reset, so BIOS cycles start on the hub
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q           <= '0;
      st_q.regs      <= {(umad_pkg::NREG-1){umad_pkg::REG_RESET}};
      st_q.rsp_tgt   <= umad_pkg::TGT_DRAM;
      st_q.last_tgt  <= umad_pkg::TGT_DRAM;
    end else begin
      st_q <= st_d;
    end
  end

  // Nothing sits between the record and the pins, so every output
  // changes only at a clock edge or when reset is asserted.
  // Outputs straight from flops
  assign wb_dat_out     = st_q.rdat;
  assign wb_ack_out     = st_q.ack;
  assign rsp_valid_out  = st_q.rsp_valid;
  assign rsp_target_out = st_q.rsp_tgt;
  assign rsp_addr_out   = st_q.rsp_addr;
  assign rsp_write_out  = st_q.rsp_write;

endmodule

// file: test/umad_chk.sv
// Port-level checker for the upper memory address decoder
`timescale 1ns/10ps
module umad_chk (
  input wire logic           clk_sys_in,
  input wire logic           reset_n_in,
  input wire logic           wb_cyc_in,
  input wire logic           wb_stb_in,
  input wire logic           wb_ack_out,
  input wire logic           req_valid_in,
  input wire logic [31:0]    req_addr_in,
  input wire logic           req_write_in,
  input wire umad_pkg::src_t req_src_in,
  input wire logic           rsp_valid_out,
  input wire umad_pkg::tgt_t rsp_target_out,
  input wire logic [31:0]    rsp_addr_out,
  input wire logic           rsp_write_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // ------------------------------------------------------------------
  // Decode port timing
  // ------------------------------------------------------------------
  rsp_timing_a: assert property (req_valid_in |=> rsp_valid_out)
    else $error("decode answer missing one cycle after request");
  rsp_quiet_a: assert property (!req_valid_in |=> !rsp_valid_out)
    else $error("decode answer without request");
  write_copy_a: assert property (req_valid_in |=>
    rsp_write_out == $past(req_write_in))
    else $error("direction not carried to answer");

  // ------------------------------------------------------------------
  // Routing relations
  // ------------------------------------------------------------------
  // Hub-bound cycles are never relocated, whatever the region
  hub_same_a: assert property (rsp_valid_out &&
    rsp_target_out == umad_pkg::TGT_HUB |-> rsp_addr_out == $past(req_addr_in))
    else $error("hub cycle address was changed");
  // DRAM sees the same address or the low SMM window, nothing else
  dram_map_a: assert property (rsp_valid_out &&
    rsp_target_out == umad_pkg::TGT_DRAM |->
    rsp_addr_out == $past(req_addr_in) ||
    rsp_addr_out == {15'h0005, $past(req_addr_in[16:0])})
    else $error("DRAM address neither kept nor SMM window");
  hub_no_term_a: assert property (req_valid_in &&
    req_src_in != umad_pkg::SRC_CPU |=> rsp_target_out != umad_pkg::TGT_TERM)
    else $error("non processor cycle terminated as processor");
  cpu_no_refuse_a: assert property (req_valid_in &&
    req_src_in == umad_pkg::SRC_CPU |=> rsp_target_out != umad_pkg::TGT_REFUSE)
    else $error("processor cycle refused");

  // ------------------------------------------------------------------
  // Register bus handshake
  // ------------------------------------------------------------------
  bus_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out)
    else $error("register access not answered next cycle");
  bus_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge longer than one cycle");

  // Main routing outcomes the bench should reach
  cover property (rsp_valid_out && rsp_target_out == umad_pkg::TGT_TERM);
  cover property (rsp_valid_out && rsp_target_out == umad_pkg::TGT_REFUSE);
  cover property (rsp_valid_out && rsp_target_out == umad_pkg::TGT_GFX);
  cover property (rsp_valid_out && rsp_target_out == umad_pkg::TGT_AGP);
endmodule

bind upper_memory_address_decoder umad_chk i_umad_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
  .req_valid_in(req_valid_in), .req_addr_in(req_addr_in),
  .req_write_in(req_write_in), .req_src_in(req_src_in),
  .rsp_valid_out(rsp_valid_out), .rsp_target_out(rsp_target_out),
  .rsp_addr_out(rsp_addr_out), .rsp_write_out(rsp_write_out));

// file: test/host_req_model.sv
// Requester model standing for the processor bus and the hub side
`timescale 1ns/10ps
module host_req_model (
  input  wire logic     clk_sys_in,
  output logic          req_valid_out,
  output logic [31:0]   req_addr_out,
  output logic          req_write_out,
  output logic          req_wb_out,
  output logic          req_smm_out,
  output umad_pkg::src_t req_src_out
);
  initial begin
    req_valid_out = 1'b0;
    req_addr_out = 32'h0;
    {req_smm_out, req_wb_out, req_write_out} = 3'h0;
    req_src_out = umad_pkg::SRC_CPU;
  end

  // One request per call; address and flags are inverted once taken so that a
  // decoder reading stale fields is not rescued by leftover values
  task automatic issue(input logic [31:0] a, input logic [2:0] f,
                       input umad_pkg::src_t s);
    @(posedge clk_sys_in);
    req_valid_out <= 1'b1;
    req_addr_out <= a;
    {req_smm_out, req_wb_out, req_write_out} <= f;
    req_src_out <= s;
    @(posedge clk_sys_in);
    req_valid_out <= 1'b0;
    req_addr_out <= ~a;
    {req_smm_out, req_wb_out, req_write_out} <= ~f;
  endtask
endmodule

// file: test/upper_memory_address_decoder_tb.sv
// Self-checking bench for the upper memory address decoder
`timescale 1ns/10ps
module upper_memory_address_decoder_tb;
  logic                 clk_sys_in, reset_n_in, cyc, stb, we, ack;
  logic                 valid, reqw, wbk, smm, rv, rw;
  logic [7:0]           adr;
  logic [31:0]          wdat, rdat, addr, ra, q;
  umad_pkg::src_t       src;
  umad_pkg::tgt_t       rt;
  int                   err_count = 0;
  int                   cmp_count = 0;

  upper_memory_address_decoder i_upper_memory_address_decoder (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .req_valid_in(valid), .req_addr_in(addr), .req_write_in(reqw),
    .req_wb_in(wbk), .req_smm_in(smm), .req_src_in(src),
    .rsp_valid_out(rv), .rsp_target_out(rt), .rsp_addr_out(ra),
    .rsp_write_out(rw));

  host_req_model i_host_req_model (
    .clk_sys_in(clk_sys_in), .req_valid_out(valid), .req_addr_out(addr),
    .req_write_out(reqw), .req_wb_out(wbk), .req_smm_out(smm),
    .req_src_out(src));

  // ------------------------------------------------------------------
  // Compare, bus and decode helpers
  // ------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_tgt(input umad_pkg::tgt_t got, input umad_pkg::tgt_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t target got %0d expected %0d", $time, got, exp);
    end
  endtask

  // Classic single access; waits on ack with no assumed latency
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, i, 2'b00};
    wdat <= d;
    @(posedge clk_sys_in);
    while (ack !== 1'b1) @(posedge clk_sys_in);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic reg_wr(input logic [3:0] i, input logic [31:0] d);
    wb(1'b1, i, d);
  endtask

  task automatic reg_rd(input logic [3:0] i, input logic [31:0] e);
    wb(1'b0, i, 32'h0);
    cmp_word(q, e);
  endtask

  // Flags f are {smm, write-back, write}; x of zero means no translation
  task automatic dec(input logic [31:0] a, input logic [2:0] f,
                     input umad_pkg::tgt_t t, input logic [31:0] x = 32'h0,
                     input umad_pkg::src_t s = umad_pkg::SRC_CPU);
    i_host_req_model.issue(a, f, s);
    @(negedge clk_sys_in);
    cmp_word({31'h0, rv}, 32'h1);
    cmp_tgt(rt, t);
    cmp_word(ra, (x == 32'h0) ? a : x);
    cmp_word({31'h0, rw}, {31'h0, f[0]});
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    tally_and_finish();
  end

  initial begin
    reset_n_in = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    reg_rd(umad_pkg::IDX_PAM, 32'h0);
    reg_wr(umad_pkg::IDX_STATUS, 32'hffff_ffff);
    reg_rd(umad_pkg::IDX_STATUS, 32'h0);
    reg_rd(4'hb, 32'h0);
    dec(32'h000f_0000, 3'b000, umad_pkg::TGT_HUB);
    dec(32'h000e_0000, 3'b000, umad_pkg::TGT_HUB);
    // Segment 0 readable, segment 1 writable, top segment readable
    reg_wr(umad_pkg::IDX_PAM, 32'h0000_0109);
    for (int k = 0; k < 4; k++) begin
      dec(32'h000e_0000 + k * 32'h4000, 3'b000,
          (k == 0) ? umad_pkg::TGT_DRAM : umad_pkg::TGT_HUB);
    end
    dec(32'h000e_4000, 3'b001, umad_pkg::TGT_DRAM);
    dec(32'h000e_0000, 3'b001, umad_pkg::TGT_HUB);
    dec(32'h000f_0000, 3'b000, umad_pkg::TGT_DRAM);
    dec(32'h000f_0000, 3'b001, umad_pkg::TGT_HUB);
    reg_wr(umad_pkg::IDX_MEMCTL, 32'h0000_3fff);
    dec(32'h1fff_0000, 3'b000, umad_pkg::TGT_DRAM);
    dec(32'h2000_0000, 3'b000, umad_pkg::TGT_HUB);
    reg_wr(umad_pkg::IDX_MEMCTL, 32'h0001_0200);
    dec(32'h00f0_0000, 3'b000, umad_pkg::TGT_HUB);
    dec(32'h00ef_fff0, 3'b001, umad_pkg::TGT_DRAM);
    dec(32'h0100_0000, 3'b000, umad_pkg::TGT_DRAM);
    dec(32'h0010_0000, 3'b000, umad_pkg::TGT_DRAM);
    dec(32'h0200_0000, 3'b000, umad_pkg::TGT_HUB);
    reg_wr(umad_pkg::IDX_HIGH_SMM_SEGMENT, 32'h0800_0000);
    reg_wr(umad_pkg::IDX_SMMCTL, 32'h0000_0001);
    dec(32'h0800_1234, 3'b100, umad_pkg::TGT_DRAM, 32'h000a_1234);
    dec(32'h0800_1234, 3'b000, umad_pkg::TGT_TERM);
    dec(32'h0801_fff0, 3'b011, umad_pkg::TGT_DRAM, 32'h000b_fff0);
    dec(32'h0800_0040, 3'b000, umad_pkg::TGT_REFUSE, 0,
        umad_pkg::SRC_HUB);
    dec(32'h0800_0040, 3'b001, umad_pkg::TGT_REFUSE, 0,
        umad_pkg::SRC_AGP);
    dec(32'h000a_1234, 3'b000, umad_pkg::TGT_HUB);
    reg_wr(umad_pkg::IDX_SMMCTL, 32'h0000_0002);
    dec(32'h01f8_0000, 3'b100, umad_pkg::TGT_DRAM);
    dec(32'h01f8_0000, 3'b000, umad_pkg::TGT_HUB);
    dec(32'h01ff_fff0, 3'b011, umad_pkg::TGT_DRAM);
    dec(32'h01f8_0000, 3'b000, umad_pkg::TGT_REFUSE, 0,
        umad_pkg::SRC_HUB);
    dec(32'h01f7_fff0, 3'b000, umad_pkg::TGT_DRAM);
    reg_wr(umad_pkg::IDX_SMMCTL, 32'h0000_0006);
    dec(32'h01f0_0000, 3'b000, umad_pkg::TGT_HUB);
    wb(1'b0, umad_pkg::IDX_STATUS, 32'h0);
    cmp_word(q & 32'h3fff_0000, 32'h01f0_0000);
    reg_wr(umad_pkg::IDX_GFXCFG, 32'h0000_0001);
    reg_wr(umad_pkg::IDX_LMEM, 32'h0101_0100);
    reg_wr(umad_pkg::IDX_MMIO, 32'h0120_0120);
    dec(32'h1010_0000, 3'b000, umad_pkg::TGT_GFX);
    dec(32'h1200_0000, 3'b001, umad_pkg::TGT_GFX);
    dec(32'h1300_0000, 3'b000, umad_pkg::TGT_HUB);
    reg_wr(umad_pkg::IDX_GFXCFG, 32'h0000_0002);
    reg_wr(umad_pkg::IDX_AGPWIN, 32'h0140_0140);
    reg_wr(umad_pkg::IDX_AGPPF, 32'h0150_0150);
    reg_wr(umad_pkg::IDX_APER, 32'h0003_0180);
    dec(32'h1400_0000, 3'b001, umad_pkg::TGT_AGP);
    dec(32'h1500_0000, 3'b000, umad_pkg::TGT_AGP);
    dec(32'h1830_0000, 3'b000, umad_pkg::TGT_DRAM);
    dec(32'h1840_0000, 3'b000, umad_pkg::TGT_HUB);
    dec(32'h1010_0000, 3'b000, umad_pkg::TGT_HUB);
    // Second reset in mid-run must close the shadowed BIOS again
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    reg_rd(umad_pkg::IDX_PAM, 32'h0);
    dec(32'h000f_0000, 3'b000, umad_pkg::TGT_HUB);
    tally_and_finish();
  end
endmodule
